// *** hw/bce_exec.sv ***
// Execution unit for compare-bump-branch, BCD correction and byte decrement, with APB registers
//
// Notes on behaviour
// RL1: Equal variant branches by offset when destination minus source is zero.
// RL2: Unequal variant branches by offset when the difference is nonzero.
// RL3: Both compare-branch variants bump the source pointer by one, taken or not.
// RL4: Compare-branch variants leave every condition flag unchanged.
// RL5: Opcode C2 is equal variant, three bytes, register destination, pointer source.
// RL6: Opcode D2 is unequal variant, same layout and operand modes.
// RL7: Compare-branch takes 18 cycles when taken, 16 when not taken.
// RL8: Branch offset is a signed byte, reach +127 to -128.
// RL9: After addition correction adds 00, 06, 60 or 66; carry set for 60/66.
// RL10: After subtraction correction adds 00, FA, A0 or 9A; carry set for A0/9A.
// RL11: Software uses BCD correction only on valid BCD sums or differences.
// RL12: BCD correction sets carry from the selected correction, clears it otherwise.
// RL13: BCD correction sets zero and sign from result; decimal and half-carry kept.
// RL14: BCD correction is two bytes, four cycles, opcodes 40 direct and 41 pointer.
// RL15: Byte decrement writes back destination minus one modulo 256.
// RL16: Byte decrement sets zero, sign, overflow; carry, decimal, half-carry kept.
// RL17: Byte decrement is two bytes, four cycles, opcodes 00 direct and 01 pointer.
// RL18: Branch target is sign-extended offset plus address past the instruction.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module bce_exec
  import bce_pkg::*;
(
  input  wire logic        MCLK_I,     // Core clock, 125 MHz
  input  wire logic        RESET_I,    // Synchronous reset, active high
  input  wire logic        PSEL_I,     // APB select
  input  wire logic        PENABLE_I,  // APB access phase
  input  wire logic        PWRITE_I,   // APB direction, high for write
  input  wire logic [7:0]  PADDR_I,    // APB byte address
  input  wire logic [31:0] PWDATA_I,   // APB write data
  output logic      [31:0] PRDATA_O,   // APB read data
  output logic             PREADY_O,   // APB ready
  output logic             PSLVERR_O   // APB error on unmapped address
);

  // ==========================================================
  // Storage
  bce_state_type state;
  logic [4:0]    cnt;
  logic          done;
  logic          bad_op;
  logic [7:0]    op;
  logic [7:0]    offset;
  logic [7:0]    opd_dst;
  logic [7:0]    opd_src;
  logic [7:0]    opd_ptr;
  logic [7:0]    flags_in;
  logic [15:0]   pc_in;
  logic [7:0]    res_value;
  logic [7:0]    res_ptr;
  logic          res_wb;
  logic          res_ind;
  logic          res_taken;
  logic [7:0]    flags_out;
  logic [15:0]   pc_out;
  logic [4:0]    cyc_last;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;

  // ==========================================================
  // APB decode
  wire apb_access = PSEL_I & PENABLE_I;
  wire apb_first  = apb_access & ~pready;
  wire apb_commit = apb_access & pready;
  wire wr_commit  = apb_commit & PWRITE_I;

  wire sel_control   = (PADDR_I == OFS_CONTROL);
  wire sel_instr     = (PADDR_I == OFS_INSTR);
  wire sel_operand   = (PADDR_I == OFS_OPERAND);
  wire sel_flags_in  = (PADDR_I == OFS_FLAGS_IN);
  wire sel_pc_in     = (PADDR_I == OFS_PC_IN);
  wire sel_result    = (PADDR_I == OFS_RESULT);
  wire sel_flags_out = (PADDR_I == OFS_FLAGS_OUT);
  wire sel_pc_out    = (PADDR_I == OFS_PC_OUT);
  wire sel_cycles    = (PADDR_I == OFS_CYCLES);
  wire addr_ok       = sel_control | sel_instr | sel_operand | sel_flags_in | sel_pc_in |
                       sel_result | sel_flags_out | sel_pc_out | sel_cycles;

  wire idle     = (state == ST_IDLE);
  // A start while busy is dropped so results of the running instruction stay coherent
  wire start_go = wr_commit & sel_control & PWDATA_I[CTL_START] & idle;

  wire [31:0] status_word = {29'h0000_0000, bad_op, done, ~idle};
  wire [31:0] result_word = {13'h0000, res_taken, res_ind, res_wb, res_ptr, res_value};
  wire [31:0] rd_word =
    sel_control   ? status_word :
    sel_instr     ? {16'h0000, offset, op} :
    sel_operand   ? {8'h00, opd_ptr, opd_src, opd_dst} :
    sel_flags_in  ? {24'h00_0000, flags_in} :
    sel_pc_in     ? {16'h0000, pc_in} :
    sel_result    ? result_word :
    sel_flags_out ? {24'h00_0000, flags_out} :
    sel_pc_out    ? {16'h0000, pc_out} :
    sel_cycles    ? {27'h000_0000, cyc_last} : RESET_WORD;

  // ==========================================================
  // Instruction decode
  // RL5 RL6 RL14 RL17: opcode decode
  wire is_eq     = (op == OPC_CMP_BUMP_EQ);
  wire is_ne     = (op == OPC_CMP_BUMP_NE);
  wire is_branch = is_eq | is_ne;
  wire is_corr   = (op == OPC_BCD_CORR_R) | (op == OPC_BCD_CORR_P);
  wire is_decr   = (op == OPC_BYTE_DECR_R) | (op == OPC_BYTE_DECR_P);
  wire is_known  = is_branch | is_corr | is_decr;

  // ==========================================================
  // Compare-branch datapath
  wire [7:0]  diff     = 8'(opd_dst - opd_src);
  wire        diff_z   = (diff == 8'h00);
  // RL1 RL2: branch condition
  wire        take     = (is_eq & diff_z) | (is_ne & ~diff_z);
  // RL18: sequential address past the instruction
  wire [15:0] seq_pc   = 16'(pc_in + (is_branch ? LEN_BRANCH : LEN_TWO));
  // RL8: signed byte offset
  wire [15:0] off_ext  = {{8{offset[7]}}, offset};
  wire [15:0] next_pc  = take ? 16'(seq_pc + off_ext) : seq_pc;
  // RL3: pointer bump
  wire [7:0]  next_ptr = is_branch ? 8'(opd_ptr + 8'h01) : opd_ptr;

  // ==========================================================
  // BCD correction datapath; the decimal flag tells a prior subtraction
  // Inputs outside valid BCD give a defined but meaningless byte
  wire [3:0] lo      = opd_dst[3:0];
  wire [3:0] hi      = opd_dst[7:4];
  wire       c_in    = flags_in[FLG_C];
  wire       h_in    = flags_in[FLG_H];
  wire       sub_mode = flags_in[FLG_D];
  wire       add_lo  = h_in | (lo > DIGIT_MAX);
  wire       add_hi  = c_in | (hi > DIGIT_MAX) | ((hi == DIGIT_MAX) & (lo > DIGIT_MAX));
  // RL9: addition corrections 00/06/60/66
  wire [7:0] add_fix = (add_lo ? FIX_ADD_LO : 8'h00) | (add_hi ? FIX_ADD_HI : 8'h00);
  // RL10: subtraction corrections 00/FA/A0/9A
  wire [7:0] sub_fix = 8'((h_in ? FIX_SUB_LO : 8'h00) + (c_in ? FIX_SUB_HI : 8'h00));
  wire [7:0] corr_value = 8'(opd_dst + (sub_mode ? sub_fix : add_fix));
  // RL12: carry out follows the high correction
  wire       corr_carry = sub_mode ? c_in : add_hi;

  // ==========================================================
  // Byte decrement datapath
  // RL15: wraps modulo 256
  wire [7:0] decr_value = 8'(opd_dst - 8'h01);
  wire       decr_ovf   = (opd_dst == SIGNED_MIN);

  // ==========================================================
  // Result selection
  wire [7:0] next_value = is_corr ? corr_value : (is_decr ? decr_value : opd_dst);
  wire [4:0] next_cycles = is_branch ? (take ? CYC_TAKEN : CYC_NOT_TAKEN) :
                           (is_corr | is_decr) ? CYC_SHORT : CYC_BAD;
  logic [7:0] next_flags;

  always_comb begin
    // RL4: compare-branch passes the flags through untouched
    next_flags = flags_in;
    if (is_corr) begin
      // RL12 RL13: carry, zero, sign; overflow left as it was
      next_flags[FLG_C] = corr_carry;
      next_flags[FLG_Z] = (corr_value == 8'h00);
      next_flags[FLG_S] = corr_value[7];
    end else if (is_decr) begin
      // RL16: zero, sign, overflow only
      next_flags[FLG_Z] = (decr_value == 8'h00);
      next_flags[FLG_S] = decr_value[7];
      next_flags[FLG_V] = decr_ovf;
    end
  end

  // ==========================================================
  // APB slave; ready is registered, so each transfer takes one wait cycle
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      pready  <= 1'b0;
      prdata  <= RESET_WORD;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_first;
      pslverr <= apb_first & ~addr_ok;
      if (apb_first & ~PWRITE_I) begin
        prdata <= rd_word;
      end
    end
  end

  // Operand registers may be rewritten while busy; results were captured at start
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      op       <= 8'h00;
      offset   <= 8'h00;
      opd_dst  <= 8'h00;
      opd_src  <= 8'h00;
      opd_ptr  <= 8'h00;
      flags_in <= 8'h00;
      pc_in    <= 16'h0000;
    end else if (wr_commit) begin
      if (sel_instr) begin
        op     <= PWDATA_I[7:0];
        offset <= PWDATA_I[15:8];
      end
      if (sel_operand) begin
        opd_dst <= PWDATA_I[7:0];
        opd_src <= PWDATA_I[15:8];
        opd_ptr <= PWDATA_I[23:16];
      end
      if (sel_flags_in) begin
        flags_in <= PWDATA_I[7:0];
      end
      if (sel_pc_in) begin
        pc_in <= PWDATA_I[15:0];
      end
    end
  end

  // ==========================================================
  // Execution sequencer: busy for exactly the instruction's cycle count
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      state     <= ST_IDLE;
      cnt       <= 5'h00;
      done      <= 1'b0;
      bad_op    <= 1'b0;
      res_value <= 8'h00;
      res_ptr   <= 8'h00;
      res_wb    <= 1'b0;
      res_ind   <= 1'b0;
      res_taken <= 1'b0;
      flags_out <= 8'h00;
      pc_out    <= 16'h0000;
      cyc_last  <= 5'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_go) begin
            // RL7: cycle budget loaded here
            cnt       <= 5'(next_cycles - 5'h01);
            cyc_last  <= next_cycles;
            state     <= ST_RUN;
            done      <= 1'b0;
            bad_op    <= ~is_known;
            res_value <= next_value;
            res_ptr   <= next_ptr;
            res_wb    <= is_corr | is_decr;
            res_ind   <= op[0];
            res_taken <= take;
            flags_out <= next_flags;
            pc_out    <= next_pc;
          end
        end
        ST_RUN: begin
          if (cnt == 5'h00) begin
            state <= ST_IDLE;
            done  <= 1'b1;
          end else begin
            cnt <= 5'(cnt - 5'h01);
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign PRDATA_O  = prdata;
  assign PREADY_O  = pready;
  assign PSLVERR_O = pslverr;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  a_eq_branch_pc: assert property ( // RL1
    (start_go && is_eq && opd_dst == opd_src) |=>
      (pc_out == 16'($past(pc_in) + LEN_BRANCH + {{8{$past(offset[7])}}, $past(offset)})))
    else $error("equal branch target wrong");
  a_ne_branch_fall: assert property ( // RL2
    (start_go && is_ne && opd_dst == opd_src) |=> (pc_out == 16'($past(pc_in) + LEN_BRANCH) && !res_taken))
    else $error("unequal branch taken on equal operands");
  a_ptr_bump_once: assert property ( // RL3
    (start_go && is_branch) |=> (res_ptr == 8'($past(opd_ptr) + 8'h01)))
    else $error("source pointer not bumped by one");
  a_branch_flags_kept: assert property ( // RL4
    (start_go && is_branch) |=> (flags_out == $past(flags_in)))
    else $error("compare-branch changed flags");

  a_taken_cycles: assert property ( // RL7
    (start_go && is_branch && take) |=> (!idle) [*8] ##1 (!idle) [*8] ##1 (!idle) [*2]
      ##1 (idle && done && cyc_last == CYC_TAKEN))
    else $error("taken branch not 18 cycles");

  a_not_taken_cycles: assert property ( // RL7
    (start_go && is_branch && !take) |=> (!idle) [*8] ##1 (!idle) [*8]
      ##1 (idle && done && cyc_last == CYC_NOT_TAKEN))
    else $error("not taken branch not 16 cycles");

  a_back_branch: assert property ( // RL8
    (start_go && is_branch && take && offset == SIGNED_MIN) |=> (pc_out == 16'($past(pc_in) - 16'h007D)))
    else $error("negative offset not sign extended");

  a_add_corr_carry: assert property ( // RL9
    (start_go && is_corr && !sub_mode && hi > DIGIT_MAX) |=> (flags_out[FLG_C]
      && res_value[7:4] == 4'($past(hi) + 4'h6 + 4'($past(lo) > DIGIT_MAX))))
    else $error("addition high correction missing");

  a_sub_corr_value: assert property ( // RL10
    (start_go && is_corr && sub_mode && c_in && h_in) |=> (res_value == 8'($past(opd_dst) + 8'h9A) && flags_out[FLG_C]))
    else $error("subtraction correction not 9A");

  a_corr_keep_dh: assert property ( // RL13
    (start_go && is_corr) |=> (flags_out[FLG_D] == $past(sub_mode) && flags_out[FLG_H] == $past(h_in)
      && flags_out[FLG_Z] == (res_value == 8'h00)))
    else $error("correction flags wrong");

  a_decr_wraps: assert property ( // RL15
    (start_go && is_decr && opd_dst == 8'h00) |=> (res_value == 8'hFF && res_wb))
    else $error("decrement does not wrap");

  a_decr_flags: assert property ( // RL16
    (start_go && is_decr) |=> (flags_out[FLG_V] == ($past(opd_dst) == SIGNED_MIN)
      && flags_out[FLG_C] == $past(c_in)))
    else $error("decrement flags wrong");

  a_short_cycles: assert property ( // RL17
    (start_go && (is_decr || is_corr)) |-> ##4 (!idle) ##1 (idle && cyc_last == CYC_SHORT))
    else $error("short instruction not 4 cycles");

  c_eq_taken:   cover property (start_go && is_eq && take);
  c_ne_taken:   cover property (start_go && is_ne && take);
  c_sub_corr:   cover property (start_go && is_corr && sub_mode);
  c_decr_ovf:   cover property (start_go && is_decr && decr_ovf);

endmodule

`default_nettype wire

// *** hw/bce_pkg.sv ***
// Package for the decimal adjust, byte decrement and compare-branch execution block
package bce_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_INSTR     = 8'h04;
  localparam logic [7:0] OFS_OPERAND   = 8'h08;
  localparam logic [7:0] OFS_FLAGS_IN  = 8'h0C;
  localparam logic [7:0] OFS_PC_IN     = 8'h10;
  localparam logic [7:0] OFS_RESULT    = 8'h14;
  localparam logic [7:0] OFS_FLAGS_OUT = 8'h18;
  localparam logic [7:0] OFS_PC_OUT    = 8'h1C;
  localparam logic [7:0] OFS_CYCLES    = 8'h20;

  // ==========================================================
  // Field positions
  localparam int CTL_START   = 0;
  localparam int STS_BUSY    = 0;
  localparam int STS_DONE    = 1;
  localparam int STS_BAD_OP  = 2;
  localparam int RES_WB      = 16;
  localparam int RES_IND     = 17;
  localparam int RES_TAKEN   = 18;
  localparam int FLG_C       = 7;
  localparam int FLG_Z       = 6;
  localparam int FLG_S       = 5;
  localparam int FLG_V       = 4;
  localparam int FLG_D       = 3;
  localparam int FLG_H       = 2;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OPC_CMP_BUMP_EQ = 8'hC2;
  localparam logic [7:0] OPC_CMP_BUMP_NE = 8'hD2;
  localparam logic [7:0] OPC_BCD_CORR_R  = 8'h40;
  localparam logic [7:0] OPC_BCD_CORR_P  = 8'h41;
  localparam logic [7:0] OPC_BYTE_DECR_R = 8'h00;
  localparam logic [7:0] OPC_BYTE_DECR_P = 8'h01;

  // ==========================================================
  // Cycle counts, lengths, corrections, reset values
  localparam logic [4:0]  CYC_TAKEN     = 5'h12;
  localparam logic [4:0]  CYC_NOT_TAKEN = 5'h10;
  localparam logic [4:0]  CYC_SHORT     = 5'h04;
  localparam logic [4:0]  CYC_BAD       = 5'h01;
  localparam logic [15:0] LEN_BRANCH    = 16'h0003;
  localparam logic [15:0] LEN_TWO       = 16'h0002;
  localparam logic [7:0]  FIX_ADD_LO    = 8'h06;
  localparam logic [7:0]  FIX_ADD_HI    = 8'h60;
  localparam logic [7:0]  FIX_SUB_LO    = 8'hFA;
  localparam logic [7:0]  FIX_SUB_HI    = 8'hA0;
  localparam logic [3:0]  DIGIT_MAX     = 4'h9;
  localparam logic [7:0]  SIGNED_MIN    = 8'h80;
  localparam logic [31:0] RESET_WORD    = 32'h0000_0000;

  typedef enum logic {ST_IDLE, ST_RUN} bce_state_type;

endpackage

// *** test/bce_exec_tb.sv ***
// Self-checking bench for the compare-branch, BCD correction and byte decrement unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end

module bce_exec_tb
  import bce_pkg::*;
;
  logic        MCLK_I;
  logic        RESET_I;
  logic        PSEL_I;
  logic        PENABLE_I;
  logic        PWRITE_I;
  logic [7:0]  PADDR_I;
  logic [31:0] PWDATA_I;
  logic [31:0] PRDATA_O;
  logic        PREADY_O;
  logic        PSLVERR_O;
  int          mismatches;
  int          total_checks;
  int          cycles;
  logic [31:0] rd;
  logic [31:0] res;
  logic [31:0] fout;
  logic [31:0] pco;
  logic [31:0] cyc;
  logic        err;
  logic        tk;
  logic [7:0]  op;
  logic [7:0]  fl;
  logic [7:0]  v;
  logic [7:0]  ev;
  logic [15:0] epc;
  logic [55:0] br_tab [5];
  logic [31:0] bcd_tab [13];
  logic [7:0]  dec_tab [4];

  bce_exec u_bce_exec (
    .MCLK_I    (MCLK_I),
    .RESET_I   (RESET_I),
    .PSEL_I    (PSEL_I),
    .PENABLE_I (PENABLE_I),
    .PWRITE_I  (PWRITE_I),
    .PADDR_I   (PADDR_I),
    .PWDATA_I  (PWDATA_I),
    .PRDATA_O  (PRDATA_O),
    .PREADY_O  (PREADY_O),
    .PSLVERR_O (PSLVERR_O)
  );

  // ==========================================================
  // Clock and hang guard
  initial begin
    MCLK_I = 1'b0;
    forever #4 MCLK_I = ~MCLK_I;
  end

  // Generous ceiling: the whole sequence needs little more than a thousand cycles
  always @(posedge MCLK_I) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("[ERR] %0t run did not finish", $time);
      final_report();
    end
  end

  // ==========================================================
  // Bus tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge MCLK_I);
    PSEL_I    <= 1'b1;
    PENABLE_I <= 1'b0;
    PWRITE_I  <= w;
    PADDR_I   <= a;
    PWDATA_I  <= wd;
    @(posedge MCLK_I);
    PENABLE_I <= 1'b1;
    // Waits as long as the slave needs; only the cycle ceiling ends a hang
    do begin
      @(posedge MCLK_I);
    end while (PREADY_O !== 1'b1);
    rd  = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I    <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask

  // Loads the operands, starts, waits for done and fetches every result register
  task automatic run_op(input logic [7:0] opc, off, dst, src, ptr, f, input logic [15:0] pc);
    apb(1'b1, OFS_INSTR, {16'h0000, off, opc});
    apb(1'b1, OFS_OPERAND, {8'h00, ptr, src, dst});
    apb(1'b1, OFS_FLAGS_IN, {24'h000000, f});
    apb(1'b1, OFS_PC_IN, {16'h0000, pc});
    apb(1'b1, OFS_CONTROL, 32'h0000_0001);
    do begin
      apb(1'b0, OFS_CONTROL, 32'h0000_0000);
    end while (rd[1:0] !== 2'b10);
    apb(1'b0, OFS_RESULT, 32'h0000_0000);
    res = rd;
    apb(1'b0, OFS_FLAGS_OUT, 32'h0000_0000);
    fout = rd;
    apb(1'b0, OFS_PC_OUT, 32'h0000_0000);
    pco = rd;
    apb(1'b0, OFS_CYCLES, 32'h0000_0000);
    cyc = rd;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // Test tables: branch {op, off, dst, src, ptr, pc}, correction {in, flags, out, carry}
  initial begin
    br_tab = '{56'hC2_7F_02_02_03_1000, 56'hC2_10_02_04_10_2000, 56'hD2_80_02_04_03_1000,
               56'hD2_05_55_55_FF_3000, 56'hD2_FE_00_FF_20_0010};
    bcd_tab = '{32'h3C_00_42_00, 32'h45_00_45_00, 32'h52_04_58_00, 32'hA5_00_05_01, 32'h9A_00_00_01,
                32'hB2_04_18_01, 32'h15_80_75_01, 32'h1B_80_81_01, 32'h32_84_98_01, 32'h45_08_45_00,
                32'h4F_0C_49_00, 32'h85_88_25_01, 32'h7E_8C_18_01};
    dec_tab = '{8'h00, 8'h01, 8'h80, 8'h10};
    mismatches   = 0;
    total_checks = 0;
    cycles       = 0;
    RESET_I   = 1'b1;
    PSEL_I    = 1'b0;
    PENABLE_I = 1'b0;
    PWRITE_I  = 1'b0;
    PADDR_I   = 8'h00;
    PWDATA_I  = 32'h0000_0000;
    repeat (5) @(posedge MCLK_I);
    RESET_I <= 1'b0;
    // Every register reads zero after reset
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0000_0000);
      `CHK(rd, RESET_WORD)
    end
    // Unmapped place: refused on write and read
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    // Compare-branch, both variants, taken and not, offset extremes, pointer wrap
    for (int i = 0; i < 5; i++) begin
      op = br_tab[i][55:48];
      fl = i[0] ? 8'h00 : 8'hFC;
      tk = (op == 8'hC2) == (br_tab[i][39:32] == br_tab[i][31:24]);
      epc = br_tab[i][15:0] + 16'h0003 + (tk ? {{8{br_tab[i][47]}}, br_tab[i][47:40]} : 16'h0000);
      run_op(op, br_tab[i][47:40], br_tab[i][39:32], br_tab[i][31:24], br_tab[i][23:16], fl, br_tab[i][15:0]);
      `CHK(res[18], tk)
      `CHK(res[15:8], br_tab[i][23:16] + 8'h01)
      `CHK(fout[7:2], fl[7:2])
      `CHK(res[17:16], 2'b00)
      `CHK(cyc, tk ? 32'h0000_0012 : 32'h0000_0010)
      `CHK(pco[15:0], epc)
    end
    // only valid BCD sums and differences are fed, every table row
    for (int i = 0; i < 13; i++) begin
      op = i[0] ? 8'h41 : 8'h40;
      fl = bcd_tab[i][23:16];
      ev = bcd_tab[i][15:8];
      run_op(op, 8'h00, bcd_tab[i][31:24], 8'h00, 8'h30, fl, 16'h0400);
      `CHK(res[7:0], ev)
      `CHK(fout[7], bcd_tab[i][0])
      `CHK({fout[6:5], fout[3:2]}, {ev == 8'h00, ev[7], fl[3:2]})
      `CHK({res[17:16], res[15:8]}, {op[0], 1'b1, 8'h30})
      `CHK({cyc, pco}, {32'h0000_0004, 32'h0000_0402})
    end
    // Byte decrement with wrap and signed overflow
    for (int i = 0; i < 4; i++) begin
      op = i[0] ? 8'h01 : 8'h00;
      fl = i[1] ? 8'h00 : 8'hFC;
      v = dec_tab[i];
      ev = v - 8'h01;
      run_op(op, 8'h00, v, 8'h00, 8'h30, fl, 16'hFFFE);
      `CHK(res[7:0], ev)
      `CHK(fout[6:4], {ev == 8'h00, ev[7], v == 8'h80})
      `CHK({fout[7], fout[3:2]}, {fl[7], fl[3:2]})
      `CHK(res[17:16], {op[0], 1'b1})
      `CHK({cyc, pco}, {32'h0000_0004, 32'h0000_0000})
    end
    // Unknown opcode: one busy cycle, operands pass through, flagged in status
    run_op(8'hFF, 8'h00, 8'h12, 8'h00, 8'h30, 8'hFC, 16'h0400);
    `CHK({cyc, res[7:0], fout[7:0]}, {32'h0000_0001, 8'h12, 8'hFC})
    apb(1'b0, OFS_CONTROL, 32'h0000_0000);
    `CHK(rd[2:0], 3'b110)
    final_report();
  end

endmodule
`default_nettype wire
